// File: logic/ccd_params.svh
// register map, field positions and reset values
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH
`define CCD_ADDR_W 10
`define CCD_ADDR_CNT0 10'h190
`define CCD_ADDR_CTL0 10'h191
`define CCD_ADDR_PWR0 10'h192
`define CCD_ADDR_CNT1 10'h193
`define CCD_ADDR_CTL1 10'h194
`define CCD_ADDR_PWR1 10'h195
`define CCD_RST_CNT0 8'h77
`define CCD_RST_CNT1 8'h33
`define CCD_RST_CTL 8'h00
`define CCD_RST_PWR 8'h00
`define CCD_LOW_MSB 7
`define CCD_LOW_LSB 4
`define CCD_HIGH_MSB 3
`define CCD_HIGH_LSB 0
`define CCD_BYPASS_BIT 7
`define CCD_IGNSYNC_BIT 6
`define CCD_FORCE_BIT 5
`define CCD_START_BIT 4
`define CCD_PHASE_MSB 3
`define CCD_PHASE_LSB 0
`define CCD_PD_BIT 2
`define CCD_CORRDIS_BIT 0
`define CCD_PWR_MASK 8'h05
`endif

// File: logic/ccd_pkg.sv
// types shared by the channel divider modules
package ccd_pkg;
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_PHASE,
    ST_RUN
  } ccd_state_t;
endpackage

// File: logic/ccd_chan_if.sv
// settings and outputs passed between register file and one channel divider
`timescale 1ns/1ps
`default_nettype none
interface ccd_chan_if;
  logic [7:0] counts;
  logic [7:0] ctrl;
  logic pd;
  logic out;
  logic oe;
  modport regs (output counts, output ctrl, output pd, input out, input oe);
  modport chan (input counts, input ctrl, input pd, output out, output oe);
endinterface
`default_nettype wire

// File: logic/ccd_divider.sv
// one channel divider: high/low counts, sync, phase, force, bypass, power-down
`timescale 1ns/1ps
`default_nettype none
`include "ccd_params.svh"
module ccd_divider
  import ccd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic dist_clk,
  input wire logic sync_req,
  ccd_chan_if.chan cfg
);
  ccd_state_t state;
  ccd_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic lvl;
  logic next_lvl;
  logic prev_in;
  logic out;
  logic next_out;
  logic oe;
  logic next_oe;
  logic tick;
  logic byp;
  logic ign;
  logic hold;

  function automatic logic [3:0] dur(input logic level, input logic [7:0] counts);
    dur = level ? counts[`CCD_HIGH_MSB:`CCD_HIGH_LSB] : counts[`CCD_LOW_MSB:`CCD_LOW_LSB];
  endfunction

  assign tick = dist_clk & ~prev_in;
  assign byp = cfg.ctrl[`CCD_BYPASS_BIT];
  assign ign = cfg.ctrl[`CCD_IGNSYNC_BIT];
  assign hold = cfg.pd | byp | ign | sync_req;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_lvl = lvl;
    if (cfg.pd || byp) begin
      next_state = ST_HOLD;
      next_lvl = cfg.ctrl[`CCD_START_BIT];
      next_cnt = cfg.ctrl[`CCD_PHASE_MSB:`CCD_PHASE_LSB];
    end else if (ign) begin
      next_state = ST_HOLD;
      next_lvl = cfg.ctrl[`CCD_FORCE_BIT];
      next_cnt = cfg.ctrl[`CCD_PHASE_MSB:`CCD_PHASE_LSB];
    end else if (sync_req) begin
      next_state = ST_HOLD;
      next_lvl = cfg.ctrl[`CCD_START_BIT];
      next_cnt = cfg.ctrl[`CCD_PHASE_MSB:`CCD_PHASE_LSB];
    end else begin
      case (state)
        ST_HOLD: begin
          next_state = ST_PHASE;
        end
        ST_PHASE: begin
          if (cnt == 4'h0) begin
            next_state = ST_RUN;
            next_cnt = dur(lvl, cfg.counts);
          end else if (tick) begin
            next_cnt = cnt - 4'h1;
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (cnt == 4'h0) begin
              next_lvl = ~lvl;
              next_cnt = dur(~lvl, cfg.counts);
            end else begin
              next_cnt = cnt - 4'h1;
            end
          end
        end
        default: begin
          next_state = ST_HOLD;
        end
      endcase
    end
  end

  always_comb begin
    next_oe = ~cfg.pd;
    if (cfg.pd) begin
      next_out = 1'b0;
    end else if (byp) begin
      next_out = dist_clk;
    end else begin
      next_out = next_lvl;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_HOLD;
      cnt <= 4'h0;
      lvl <= 1'b0;
      prev_in <= 1'b0;
      out <= 1'b0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      lvl <= next_lvl;
      prev_in <= dist_clk;
      out <= next_out;
      oe <= next_oe;
    end
  end

  assign cfg.out = out;
  assign cfg.oe = oe;

  sequence s_run_wrap(logic level);
    state == ST_RUN && !hold && tick && cnt == 4'h0 && lvl == level;
  endsequence

  property p_high_end;
    @(posedge clk) disable iff (reset)
    s_run_wrap(1'b1) |=> !lvl && cnt == $past(cfg.counts[`CCD_LOW_MSB:`CCD_LOW_LSB]);
  endproperty
  a_high_end: assert property (p_high_end) else $error("low count not reloaded");

  property p_low_end;
    @(posedge clk) disable iff (reset)
    s_run_wrap(1'b0) |=> lvl && cnt == $past(cfg.counts[`CCD_HIGH_MSB:`CCD_HIGH_LSB]);
  endproperty
  a_low_end: assert property (p_low_end) else $error("high count not reloaded");

  property p_bypass;
    @(posedge clk) disable iff (reset)
    !cfg.pd && byp |=> out == $past(dist_clk) && state == ST_HOLD;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output not following input");

  property p_force;
    @(posedge clk) disable iff (reset)
    !cfg.pd && !byp && ign |=> out == $past(cfg.ctrl[`CCD_FORCE_BIT]);
  endproperty
  a_force: assert property (p_force) else $error("forced level wrong");

  property p_sync_hold;
    @(posedge clk) disable iff (reset)
    !cfg.pd && !byp && !ign && sync_req ##1 !hold |=> state == ST_PHASE && out == lvl;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("no phase after sync");

  property p_phase_step;
    @(posedge clk) disable iff (reset)
    state == ST_PHASE && !hold && tick && cnt != 4'h0 |=> cnt == $past(cnt) - 4'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase count did not step");

  property p_pd_hiz;
    @(posedge clk) disable iff (reset)
    cfg.pd |=> !oe && !out;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("powered down channel still driving");
endmodule
`default_nettype wire

// File: logic/ccd_top.sv
// register file and two output channel dividers with three driven outputs each
`timescale 1ns/1ps
`default_nettype none
`include "ccd_params.svh"
module ccd_top
  import ccd_pkg::*;
#(
  parameter logic [7:0] CNT0_RESET = `CCD_RST_CNT0,
  parameter logic [7:0] CNT1_RESET = `CCD_RST_CNT1
)(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic DIST_CLK,
  input wire logic SYNC_REQ,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [`CCD_ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic CHAN0_OUTPUT_A,
  output logic CHAN0_OUTPUT_A_OE,
  output logic CHAN0_OUTPUT_B,
  output logic CHAN0_OUTPUT_B_OE,
  output logic CHAN0_OUTPUT_C,
  output logic CHAN0_OUTPUT_C_OE,
  output logic CHAN1_OUTPUT_A,
  output logic CHAN1_OUTPUT_A_OE,
  output logic CHAN1_OUTPUT_B,
  output logic CHAN1_OUTPUT_B_OE,
  output logic CHAN1_OUTPUT_C,
  output logic CHAN1_OUTPUT_C_OE,
  output logic DUTY_CYCLE_CORRECTION_EN0,
  output logic DUTY_CYCLE_CORRECTION_EN1
);
  logic [7:0] cnt0;
  logic [7:0] ctl0;
  logic [7:0] pwr0;
  logic [7:0] cnt1;
  logic [7:0] ctl1;
  logic [7:0] pwr1;
  logic [7:0] rdata;
  logic corr0;
  logic corr1;
  logic [7:0] next_cnt0;
  logic [7:0] next_ctl0;
  logic [7:0] next_pwr0;
  logic [7:0] next_cnt1;
  logic [7:0] next_ctl1;
  logic [7:0] next_pwr1;
  logic [7:0] next_rdata;
  logic next_corr0;
  logic next_corr1;

  ccd_chan_if ch0 ();
  ccd_chan_if ch1 ();

  function automatic logic hit(input logic [`CCD_ADDR_W-1:0] a, input logic [`CCD_ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  always_comb begin
    next_cnt0 = cnt0;
    next_ctl0 = ctl0;
    next_pwr0 = pwr0;
    next_cnt1 = cnt1;
    next_ctl1 = ctl1;
    next_pwr1 = pwr1;
    if (REG_WE) begin
      if (hit(REG_ADDR, `CCD_ADDR_CNT0)) begin
        next_cnt0 = REG_WDATA;
      end
      if (hit(REG_ADDR, `CCD_ADDR_CTL0)) begin
        next_ctl0 = REG_WDATA;
      end
      if (hit(REG_ADDR, `CCD_ADDR_PWR0)) begin
        next_pwr0 = REG_WDATA & `CCD_PWR_MASK;
      end
      if (hit(REG_ADDR, `CCD_ADDR_CNT1)) begin
        next_cnt1 = REG_WDATA;
      end
      if (hit(REG_ADDR, `CCD_ADDR_CTL1)) begin
        next_ctl1 = REG_WDATA;
      end
      if (hit(REG_ADDR, `CCD_ADDR_PWR1)) begin
        next_pwr1 = REG_WDATA & `CCD_PWR_MASK;
      end
    end
    next_corr0 = ~next_pwr0[`CCD_CORRDIS_BIT];
    next_corr1 = ~next_pwr1[`CCD_CORRDIS_BIT];
  end

  always_comb begin
    next_rdata = rdata;
    if (REG_RE) begin
      case (REG_ADDR)
        `CCD_ADDR_CNT0: next_rdata = cnt0;
        `CCD_ADDR_CTL0: next_rdata = ctl0;
        `CCD_ADDR_PWR0: next_rdata = pwr0;
        `CCD_ADDR_CNT1: next_rdata = cnt1;
        `CCD_ADDR_CTL1: next_rdata = ctl1;
        `CCD_ADDR_PWR1: next_rdata = pwr1;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt0 <= CNT0_RESET;
      cnt1 <= CNT1_RESET;
      ctl0 <= `CCD_RST_CTL;
      ctl1 <= `CCD_RST_CTL;
      pwr0 <= `CCD_RST_PWR;
      pwr1 <= `CCD_RST_PWR;
      rdata <= 8'h00;
      corr0 <= 1'b1;
      corr1 <= 1'b1;
    end else begin
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
      ctl0 <= next_ctl0;
      ctl1 <= next_ctl1;
      pwr0 <= next_pwr0;
      pwr1 <= next_pwr1;
      rdata <= next_rdata;
      corr0 <= next_corr0;
      corr1 <= next_corr1;
    end
  end

  assign ch0.counts = cnt0;
  assign ch0.ctrl = ctl0;
  assign ch0.pd = pwr0[`CCD_PD_BIT];
  assign ch1.counts = cnt1;
  assign ch1.ctrl = ctl1;
  assign ch1.pd = pwr1[`CCD_PD_BIT];

  ccd_divider u_div0 (
    .clk(CLK),
    .reset(RESET),
    .dist_clk(DIST_CLK),
    .sync_req(SYNC_REQ),
    .cfg(ch0.chan)
  );

  ccd_divider u_div1 (
    .clk(CLK),
    .reset(RESET),
    .dist_clk(DIST_CLK),
    .sync_req(SYNC_REQ),
    .cfg(ch1.chan)
  );

  assign CHAN0_OUTPUT_A = ch0.out;
  assign CHAN0_OUTPUT_B = ch0.out;
  assign CHAN0_OUTPUT_C = ch0.out;
  assign CHAN0_OUTPUT_A_OE = ch0.oe;
  assign CHAN0_OUTPUT_B_OE = ch0.oe;
  assign CHAN0_OUTPUT_C_OE = ch0.oe;
  assign CHAN1_OUTPUT_A = ch1.out;
  assign CHAN1_OUTPUT_B = ch1.out;
  assign CHAN1_OUTPUT_C = ch1.out;
  assign CHAN1_OUTPUT_A_OE = ch1.oe;
  assign CHAN1_OUTPUT_B_OE = ch1.oe;
  assign CHAN1_OUTPUT_C_OE = ch1.oe;
  assign REG_RDATA = rdata;
  assign DUTY_CYCLE_CORRECTION_EN0 = corr0;
  assign DUTY_CYCLE_CORRECTION_EN1 = corr1;

  property p_reset_cnt0;
    @(posedge CLK) RESET |=> cnt0 == `CCD_RST_CNT0 || RESET;
  endproperty
  a_reset_cnt0: assert property (p_reset_cnt0) else $error("channel 0 counts not reset");

  property p_reset_cnt1;
    @(posedge CLK) RESET ##1 !RESET |-> cnt1 == `CCD_RST_CNT1 && ctl1 == `CCD_RST_CTL;
  endproperty
  a_reset_cnt1: assert property (p_reset_cnt1) else $error("channel 1 counts not reset");

  property p_corr0;
    @(posedge CLK) disable iff (RESET)
    REG_WE && REG_ADDR == `CCD_ADDR_PWR0 |=> DUTY_CYCLE_CORRECTION_EN0 == !$past(REG_WDATA[0]);
  endproperty
  a_corr0: assert property (p_corr0) else $error("correction enable 0 wrong");

  property p_corr1;
    @(posedge CLK) disable iff (RESET)
    REG_WE && REG_ADDR == `CCD_ADDR_PWR1 |=> DUTY_CYCLE_CORRECTION_EN1 == !$past(REG_WDATA[0]);
  endproperty
  a_corr1: assert property (p_corr1) else $error("correction enable 1 wrong");

  property p_cnt_write;
    @(posedge CLK) disable iff (RESET)
    REG_WE && REG_ADDR == `CCD_ADDR_CNT1 |=> cnt1 == $past(REG_WDATA);
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

  property p_cnt_read;
    @(posedge CLK) disable iff (RESET)
    REG_RE && REG_ADDR == `CCD_ADDR_CNT0 |=> REG_RDATA == $past(cnt0);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count readback wrong");

  property p_pd_pins0;
    @(posedge CLK) disable iff (RESET)
    REG_WE && REG_ADDR == `CCD_ADDR_PWR0 && REG_WDATA[2] ##1 !REG_WE |=>
      !CHAN0_OUTPUT_A_OE && !CHAN0_OUTPUT_B_OE && !CHAN0_OUTPUT_C_OE;
  endproperty
  a_pd_pins0: assert property (p_pd_pins0) else $error("channel 0 pins not released");

  property p_pd_pins;
    @(posedge CLK) disable iff (RESET)
    REG_WE && REG_ADDR == `CCD_ADDR_PWR1 && REG_WDATA[2] ##1 !REG_WE |=>
      !CHAN1_OUTPUT_A_OE && !CHAN1_OUTPUT_B_OE && !CHAN1_OUTPUT_C_OE;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("channel 1 pins not released");
endmodule
`default_nettype wire

// File: testbench/channel_clock_divider_test.sv
// self-checking bench for the two-channel clock divider
`timescale 1ns/1ps
`default_nettype none
`include "ccd_params.svh"
module channel_clock_divider_test;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic DIST_CLK = 1'b0;
  logic SYNC_REQ = 1'b1;
  logic REG_WE = 1'b0;
  logic REG_RE = 1'b0;
  logic [`CCD_ADDR_W-1:0] REG_ADDR = 10'h000;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA;
  wire [1:0] out_a, out_b, out_c, oe_a, oe_b, oe_c, corr_en;
  int n_errors = 0;
  int checks = 0;
  int regs [6] = '{8'h77, 0, 0, 8'h33, 0, 0};
  logic [31:0] seed = 32'h0000002D;
  int d0, d1, p, v, n, ch;

  ccd_top DUT (.CLK(CLK), .RESET(RESET), .DIST_CLK(DIST_CLK), .SYNC_REQ(SYNC_REQ),
    .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .CHAN0_OUTPUT_A(out_a[0]), .CHAN0_OUTPUT_A_OE(oe_a[0]),
    .CHAN0_OUTPUT_B(out_b[0]), .CHAN0_OUTPUT_B_OE(oe_b[0]), .CHAN0_OUTPUT_C(out_c[0]),
    .CHAN0_OUTPUT_C_OE(oe_c[0]), .CHAN1_OUTPUT_A(out_a[1]), .CHAN1_OUTPUT_A_OE(oe_a[1]),
    .CHAN1_OUTPUT_B(out_b[1]), .CHAN1_OUTPUT_B_OE(oe_b[1]), .CHAN1_OUTPUT_C(out_c[1]),
    .CHAN1_OUTPUT_C_OE(oe_c[1]), .DUTY_CYCLE_CORRECTION_EN0(corr_en[0]),
    .DUTY_CYCLE_CORRECTION_EN1(corr_en[1]));

  always #20 CLK = ~CLK;
  // divider input: one rising edge every two cycles
  always @(negedge CLK) begin
    DIST_CLK <= ~DIST_CLK;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic summarize();
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input int a, input logic [7:0] d);
    int idx;
    idx = a - 'h190;
    @(negedge CLK);
    REG_WE = 1'b1;
    REG_ADDR = a[9:0];
    REG_WDATA = d;
    @(negedge CLK);
    REG_WE = 1'b0;
    if (idx >= 0 && idx < 6) begin
      regs[idx] = (idx == 2 || idx == 5) ? (d & 8'h05) : d;
    end
  endtask

  task automatic rd(input int a);
    int idx;
    idx = a - 'h190;
    @(negedge CLK);
    REG_RE = 1'b1;
    REG_ADDR = a[9:0];
    @(negedge CLK);
    REG_RE = 1'b0;
    chk("reg_read", REG_RDATA, (idx >= 0 && idx < 6) ? regs[idx] : 0);
  endtask

  task automatic wait_lvl(input int c, input logic lvl);
    int i;
    for (i = 0; i < 300 && out_a[c] !== lvl; i++) begin
      @(negedge CLK);
    end
    if (out_a[c] !== lvl) begin
      chk("timeout", 8'h01, 8'h00);
      summarize();
    end
  endtask

  // cycles spent at one level, over a whole segment entered from the opposite level
  task automatic run_len(input int c, input logic lvl, output int len);
    wait_lvl(c, ~lvl);
    wait_lvl(c, lvl);
    len = 0;
    while (out_a[c] === lvl && len < 300) begin
      len++;
      @(negedge CLK);
    end
    if (len >= 300) begin
      chk("timeout", 8'h01, 8'h00);
      summarize();
    end
  endtask

  task automatic meas(input int c, input int hi, input int lo);
    int len;
    run_len(c, 1'b1, len);
    chk("high_len", len, 2 * (hi + 1));
    run_len(c, 1'b0, len);
    chk("low_len", len, 2 * (lo + 1));
  endtask

  // cycles from sync release to first edge of channel 1
  task automatic sync_delay(input logic s, input int ph, output int d);
    wr('h194, {3'b000, s, ph[3:0]});
    SYNC_REQ = 1'b1;
    repeat (6) @(negedge CLK);
    chk("start_level", out_a[1], s);
    for (d = 0; d < 4 && DIST_CLK !== 1'b0; d++) begin
      @(negedge CLK);
    end
    SYNC_REQ = 1'b0;
    d = 0;
    while (out_a[1] === s && d < 300) begin
      d++;
      @(negedge CLK);
    end
    if (d >= 300) begin
      chk("timeout", 8'h01, 8'h00);
      summarize();
    end
  endtask

  initial begin
    repeat (5) @(negedge CLK);
    RESET = 1'b0;
    SYNC_REQ = 1'b0;
    for (v = 'h190; v < 'h197; v++) rd(v);
    chk("corr_en", corr_en, 8'h03);
    chk("oe", {oe_a, oe_b, oe_c}, 8'h3F);
    meas(0, 7, 7);
    meas(1, 3, 3);
    wr('h196, 8'hAA);
    rd('h196);
    for (v = 0; v < 4; v++) begin
      p = (v == 0) ? 0 : int'(xs() & 32'hFF);
      wr('h193, p[7:0]);
      rd('h193);
      meas(1, p & 15, p >> 4);
    end
    for (v = 0; v < 2; v++) begin
      sync_delay(v[0], 0, d0);
      n = int'(xs() % 15) + 1;
      sync_delay(v[0], n, d1);
      chk("phase_delay", d1 - d0, 2 * n);
    end
    wr('h194, 8'h20);
    meas(1, p & 15, p >> 4);
    for (v = 0; v < 2; v++) begin
      wr('h194, v[0] ? 8'h60 : 8'h40);
      SYNC_REQ = v[0];
      repeat (3) @(negedge CLK);
      for (n = 0; n < 40; n++) begin
        chk("forced", out_a[1], v[0]);
        @(negedge CLK);
      end
    end
    SYNC_REQ = 1'b0;
    wr('h193, 8'hFF);
    wr('h194, 8'hA0);
    // bypass: output follows the input, high one cycle and low one cycle
    for (ch = 0; ch < 2; ch++) begin
      run_len(1, 1'b1, n);
      chk("bypass_high", n, 8'h01);
      run_len(1, 1'b0, n);
      chk("bypass_low", n, 8'h01);
      wr('h194, 8'hE0);
    end
    for (ch = 0; ch < 2; ch++) begin
      wr('h192 + 3 * ch, 8'hFF);
      rd('h192 + 3 * ch);
      repeat (2) @(negedge CLK);
      chk("pd_oe", {oe_a[ch], oe_b[ch], oe_c[ch]}, 8'h00);
      chk("pd_out", {out_a[ch], out_b[ch], out_c[ch]}, 8'h00);
      chk("pd_other_oe", oe_a[1 - ch], 8'h01);
      chk("corr_off", corr_en[ch], 8'h00);
      wr('h192 + 3 * ch, 8'h00);
      repeat (2) @(negedge CLK);
      chk("oe_back", {oe_a[ch], oe_b[ch], oe_c[ch], corr_en[ch]}, 8'h0F);
    end
    // mid-run reset brings back the defaults
    RESET = 1'b1;
    repeat (2) @(negedge CLK);
    RESET = 1'b0;
    regs = '{8'h77, 0, 0, 8'h33, 0, 0};
    rd('h193);
    meas(1, 3, 3);
    chk("corr_en", corr_en, 8'h03);
    summarize();
  end
endmodule
`default_nettype wire
